/* File: tsy_map.svh */
// register map and field positions of the timer sync and output gate block
// assumes inclusion by bare name from the top module and the test bench
`ifndef TSY_MAP_SVH
`define TSY_MAP_SVH

// ====================================================
// register offsets on the plain register port
`define TSY_ADDR_W          4
`define TSY_OFS_SYNC_SEL    4'h0
`define TSY_OFS_OUT_MASTER  4'h1

// ====================================================
// channel_sync_select fields
`define TSY_SYNC_CH4        7
`define TSY_SYNC_CH3        6
`define TSY_SYNC_CH2        2
`define TSY_SYNC_CH1        1
`define TSY_SYNC_CH0        0
`define TSY_SYNC_WMASK      8'hC7
`define TSY_SYNC_RESET      8'h00

// ====================================================
// output_master_enable fields
`define TSY_GATE_CH4_PIN_D  5
`define TSY_GATE_CH4_PIN_C  4
`define TSY_GATE_CH3_PIN_D  3
`define TSY_GATE_CH4_PIN_B  2
`define TSY_GATE_CH4_PIN_A  1
`define TSY_GATE_CH3_PIN_B  0
`define TSY_GATE_WMASK      8'h3F
`define TSY_GATE_FIXED_ONES 8'hC0
`define TSY_GATE_RESET      8'hC0

`endif

/* File: tsy_out_gate.sv */
// per pin gate of the timer waveform onto the six channel 3 and 4 pins
// assumes waveform level and drive request come from compare logic on clk
module tsy_out_gate (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire tsy_pkg::tsy_pin_t gate_en,
    input  wire tsy_pkg::tsy_pin_t wave_lvl,
    input  wire tsy_pkg::tsy_pin_t wave_drive,
    output tsy_pkg::tsy_pin_t     pin_out_q,
    output tsy_pkg::tsy_pin_t     pin_oe_q
);
    tsy_pkg::tsy_pin_t pin_out_d;
    tsy_pkg::tsy_pin_t pin_oe_d;

    // gate blocks waveform
    // a closed gate releases the pin and holds the data low
    for (genvar p = 0; p < 6; p++) begin : g_pin
        always_comb begin
            pin_oe_d[p]  = gate_en[p] & wave_drive[p];
            pin_out_d[p] = gate_en[p] & wave_lvl[p];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_out_q <= 6'h00;
            pin_oe_q  <= 6'h00;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_q  <= pin_oe_d;
        end
    end
endmodule : tsy_out_gate

/* File: tsy_pkg.sv */
// types shared by the timer sync and output gate block
// assumes tsy_map.svh is on the include path
package tsy_pkg;
    // one bit per timer channel, bit n is channel n
    typedef logic [4:0] tsy_chan_t;
    // one bit per gated pin, ordered as the gate register bits
    typedef logic [5:0] tsy_pin_t;
    typedef logic [7:0] tsy_reg_t;
endpackage : tsy_pkg

/* File: tsy_sync_group.sv */
// preset and clear distribution across the synchronous channel group
// assumes one counter write per cycle from the register side of the timer
module tsy_sync_group #(
    parameter int CNT_W = 16
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire tsy_pkg::tsy_chan_t sync_sel,
    input  wire tsy_pkg::tsy_chan_t cnt_wr_req,
    input  wire logic [CNT_W-1:0]  cnt_wr_data,
    input  wire tsy_pkg::tsy_chan_t clr_event,
    input  wire tsy_pkg::tsy_chan_t clr_src_sync,
    output tsy_pkg::tsy_chan_t     preset_en_q,
    output logic [CNT_W-1:0]       preset_val_q,
    output tsy_pkg::tsy_chan_t     clear_q
);
    tsy_pkg::tsy_chan_t preset_en_d;
    tsy_pkg::tsy_chan_t clear_d;
    logic               grp_wr;
    logic               grp_clr;

    // ungrouped stay private
    // a write or clear in the group fans out; ungrouped channels see only their own
    always_comb begin
        grp_wr  = |(cnt_wr_req & sync_sel);
        grp_clr = |(clr_event & sync_sel);
        for (int i = 0; i < 5; i++) begin
            preset_en_d[i] = cnt_wr_req[i] | (sync_sel[i] & grp_wr);
            // own source always clears; follow the group only if steered to it
            clear_d[i]     = clr_event[i] | (sync_sel[i] & clr_src_sync[i] & grp_clr);
        end
    end

    // registered so every output leaves from a flip-flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            preset_en_q  <= 5'h00;
            preset_val_q <= '0;
            clear_q      <= 5'h00;
        end else begin
            preset_en_q  <= preset_en_d;
            preset_val_q <= cnt_wr_data;
            clear_q      <= clear_d;
        end
    end
endmodule : tsy_sync_group

/* File: tsy_top.sv */
// timer channel synchronisation and output master gate, top level
// assumes counters, compare logic and pin muxes sit outside on clk
//
// Overview of operation
// - channel_sync_select is an 8-bit read/write register, one choice per channel.
// - a set sync bit puts that channel's counter into the synchronous group.
// - grouped counters preset together and clear when another grouped one clears.
// - sync clear needs both the sync bit and the sync clear source selected.
// - a channel with sync bit 0 presets and clears on its own only.
// - sync bits sit at 7,6 for channels 4,3 and 2..0; all reset 0.
// - sync register bits 5..3 read 0; software writes 0 there.
// - output_master_enable, 8-bit read/write, gates six channel 3 and 4 pins.
// - gate bits 5..0 map to ch4 D, ch4 C, ch3 D, ch4 B, ch4 A, ch3 B.
// - gate bit 0 blocks the timer output on its pin, 1 passes it.
// - gate bits 7,6 read 1; software writes 1; reset value is all ones there.
`include "tsy_map.svh"

module tsy_top #(
    parameter int CNT_W = 16
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire logic [`TSY_ADDR_W-1:0] reg_addr,
    input  wire tsy_pkg::tsy_reg_t     reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output tsy_pkg::tsy_reg_t          reg_rdata_q,
    input  wire tsy_pkg::tsy_chan_t    cnt_wr_req,
    input  wire logic [CNT_W-1:0]      cnt_wr_data,
    input  wire tsy_pkg::tsy_chan_t    clr_event,
    input  wire tsy_pkg::tsy_chan_t    clr_src_sync,
    output tsy_pkg::tsy_chan_t         preset_en_q,
    output logic [CNT_W-1:0]           preset_val_q,
    output tsy_pkg::tsy_chan_t         clear_q,
    input  wire tsy_pkg::tsy_pin_t     wave_lvl,
    input  wire tsy_pkg::tsy_pin_t     wave_drive,
    output tsy_pkg::tsy_pin_t          pin_out_q,
    output tsy_pkg::tsy_pin_t          pin_oe_q
);

    // ====================================================
    // register file
    tsy_pkg::tsy_reg_t  sync_sel_q;
    tsy_pkg::tsy_reg_t  sync_sel_d;
    tsy_pkg::tsy_reg_t  master_en_q;
    tsy_pkg::tsy_reg_t  master_en_d;
    tsy_pkg::tsy_reg_t  reg_rdata_d;
    tsy_pkg::tsy_chan_t sync_vec;
    tsy_pkg::tsy_pin_t  gate_vec;

    // sync select store: reserved bits never hold a one
    // gate store: top two bits are forced to one whatever is written
    always_comb begin
        sync_sel_d  = sync_sel_q;
        master_en_d = master_en_q;
        reg_rdata_d = 8'h00;
        if (reg_wr && reg_addr == `TSY_OFS_SYNC_SEL) begin
            sync_sel_d = reg_wdata & `TSY_SYNC_WMASK;
        end
        if (reg_wr && reg_addr == `TSY_OFS_OUT_MASTER) begin
            master_en_d = (reg_wdata & `TSY_GATE_WMASK) | `TSY_GATE_FIXED_ONES;
        end
        // read data stand only in the cycle after the read strobe
        if (reg_rd) begin
            unique case (reg_addr)
                `TSY_OFS_SYNC_SEL:   reg_rdata_d = sync_sel_q;
                `TSY_OFS_OUT_MASTER: reg_rdata_d = master_en_q;
                default:             reg_rdata_d = 8'h00;  // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_sel_q  <= `TSY_SYNC_RESET;
            master_en_q <= `TSY_GATE_RESET;
            reg_rdata_q <= 8'h00;
        end else begin
            sync_sel_q  <= sync_sel_d;
            master_en_q <= master_en_d;
            reg_rdata_q <= reg_rdata_d;
        end
    end

    // gather the split sync fields into channel order
    // gate bits are already in pin order, low six bits
    always_comb begin
        sync_vec[4] = sync_sel_q[`TSY_SYNC_CH4];
        sync_vec[3] = sync_sel_q[`TSY_SYNC_CH3];
        sync_vec[2] = sync_sel_q[`TSY_SYNC_CH2];
        sync_vec[1] = sync_sel_q[`TSY_SYNC_CH1];
        sync_vec[0] = sync_sel_q[`TSY_SYNC_CH0];
        gate_vec    = master_en_q[`TSY_GATE_CH4_PIN_D:`TSY_GATE_CH3_PIN_B];
    end

    // ====================================================
    // synchronous group
    // group membership steers preset and clear fan-out
    // a lone member only ever sees its own events
    tsy_sync_group #(
        .CNT_W (CNT_W)
    ) i_tsy_sync_group (
        .clk          (clk),
        .nrst         (nrst),
        .sync_sel     (sync_vec),
        .cnt_wr_req   (cnt_wr_req),
        .cnt_wr_data  (cnt_wr_data),
        .clr_event    (clr_event),
        .clr_src_sync (clr_src_sync),
        .preset_en_q  (preset_en_q),
        .preset_val_q (preset_val_q),
        .clear_q      (clear_q)
    );

    // ====================================================
    // output master gate
    // six pins pass through the gate
    // a late gate write still takes effect, just one cycle after it lands
    tsy_out_gate i_tsy_out_gate (
        .clk        (clk),
        .nrst       (nrst),
        .gate_en    (gate_vec),
        .wave_lvl   (wave_lvl),
        .wave_drive (wave_drive),
        .pin_out_q  (pin_out_q),
        .pin_oe_q   (pin_oe_q)
    );

    // ====================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_rd_sync;
        reg_rd && reg_addr == `TSY_OFS_SYNC_SEL;
    endsequence

    sequence s_rd_gate;
        reg_rd && reg_addr == `TSY_OFS_OUT_MASTER;
    endsequence

    sequence s_wr_sync;
        reg_wr && reg_addr == `TSY_OFS_SYNC_SEL;
    endsequence

    sequence s_wr_gate;
        reg_wr && reg_addr == `TSY_OFS_OUT_MASTER;
    endsequence

    sequence s_open_ch3_pin_b;
        reg_wr && reg_addr == `TSY_OFS_OUT_MASTER && reg_wdata[`TSY_GATE_CH3_PIN_B];
    endsequence

    chk_sync_rsvd_zero: assert property (
        s_rd_sync |=> (reg_rdata_q & ~`TSY_SYNC_WMASK) == 8'h00)
        else $error("sync select reserved bits read nonzero");

    chk_gate_rsvd_one: assert property (
        s_rd_gate |=> (reg_rdata_q & `TSY_GATE_FIXED_ONES) == `TSY_GATE_FIXED_ONES)
        else $error("gate reserved bits did not read one");

    chk_sync_readback: assert property (
        s_wr_sync ##1 (s_rd_sync and !reg_wr)
        |=> reg_rdata_q == ($past(reg_wdata, 2) & `TSY_SYNC_WMASK))
        else $error("sync select read back differs from write");

    chk_rdata_idle: assert property (
        !reg_rd |=> reg_rdata_q == 8'h00)
        else $error("read data present without a read");

    chk_group_preset: assert property (
        |(cnt_wr_req & sync_vec)
        |=> (preset_en_q & $past(sync_vec)) == $past(sync_vec))
        else $error("grouped channel missed a shared preset");

    chk_indep_preset: assert property (
        !(|(cnt_wr_req & sync_vec))
        |=> preset_en_q == $past(cnt_wr_req))
        else $error("preset leaked to an unrelated channel");

    chk_preset_value: assert property (
        |cnt_wr_req |=> preset_val_q == $past(cnt_wr_data))
        else $error("preset value not the written value");

    chk_sync_clear: assert property (
        (|(clr_event & sync_vec))
        |=> (clear_q & $past(sync_vec & clr_src_sync))
            == $past(sync_vec & clr_src_sync))
        else $error("grouped clear not propagated");

    chk_clear_gated: assert property (
        1'b1 |=> (clear_q & ~$past(clr_event) & ~$past(sync_vec & clr_src_sync)) == 5'h00)
        else $error("clear reached a channel not steered to it");

    chk_gate_closed: assert property (
        gate_vec == 6'h00 |=> pin_oe_q == 6'h00 && pin_out_q == 6'h00)
        else $error("closed gate still drives a pin");

    chk_gate_open: assert property (
        gate_vec == 6'h3F
        |=> pin_oe_q == $past(wave_drive) && pin_out_q == $past(wave_lvl))
        else $error("open gate blocks the waveform");

    chk_gate_pin_map: assert property (
        ##1 (pin_oe_q & ~$past(gate_vec)) == 6'h00)
        else $error("pin driven without its own gate bit");

    chk_gate_write_lag: assert property (
        reg_wr && reg_addr == `TSY_OFS_OUT_MASTER && reg_wdata[0] == 1'b0
        ##1 !reg_wr[*1]
        |=> pin_oe_q[0] == 1'b0)
        else $error("gate close did not reach pin in two cycles");

    // ====================================================
    // register store and read path checks

    chk_sync_store_mask: assert property (
        (sync_sel_q & ~`TSY_SYNC_WMASK) == 8'h00)
        else $error("sync select holds a one in a reserved bit");

    chk_gate_fixed_store: assert property (
        (master_en_q & `TSY_GATE_FIXED_ONES) == `TSY_GATE_FIXED_ONES)
        else $error("gate register lost a fixed one");

    chk_sync_hold: assert property (
        !(reg_wr && reg_addr == `TSY_OFS_SYNC_SEL) |=> $stable(sync_sel_q))
        else $error("sync select changed without a write to it");

    chk_gate_hold: assert property (
        !(reg_wr && reg_addr == `TSY_OFS_OUT_MASTER) |=> $stable(master_en_q))
        else $error("gate register changed without a write to it");

    chk_sync_rd_data: assert property (
        s_rd_sync |=> reg_rdata_q == $past(sync_sel_q))
        else $error("sync select read data differ from the store");

    chk_gate_rd_data: assert property (
        s_rd_gate |=> reg_rdata_q == $past(master_en_q))
        else $error("gate read data differ from the store");

    chk_rd_unmapped: assert property (
        reg_rd && reg_addr != `TSY_OFS_SYNC_SEL && reg_addr != `TSY_OFS_OUT_MASTER
        |=> reg_rdata_q == 8'h00)
        else $error("unmapped address read nonzero");

    chk_gate_readback: assert property (
        s_wr_gate ##1 (s_rd_gate and !reg_wr)
        |=> reg_rdata_q == (($past(reg_wdata, 2) & `TSY_GATE_WMASK) | `TSY_GATE_FIXED_ONES))
        else $error("gate read back differs from write");

    // ====================================================
    // preset and clear checks

    chk_preset_idle: assert property (
        cnt_wr_req == 5'h00 |=> preset_en_q == 5'h00)
        else $error("preset without any counter write");

    chk_clear_idle: assert property (
        clr_event == 5'h00 |=> clear_q == 5'h00)
        else $error("clear without any clear event");

    chk_own_preset: assert property (
        1'b1 |=> (preset_en_q & $past(cnt_wr_req)) == $past(cnt_wr_req))
        else $error("written channel missed its own preset");

    chk_own_clear: assert property (
        1'b1 |=> (clear_q & $past(clr_event)) == $past(clr_event))
        else $error("channel missed its own clear");

    chk_ungrouped_preset: assert property (
        1'b1 |=> (preset_en_q & ~$past(sync_vec)) == ($past(cnt_wr_req) & ~$past(sync_vec)))
        else $error("ungrouped channel preset by another channel");

    chk_ungrouped_clear: assert property (
        1'b1 |=> (clear_q & ~$past(sync_vec)) == ($past(clr_event) & ~$past(sync_vec)))
        else $error("ungrouped channel cleared by another channel");

    // ====================================================
    // pin gate checks

    chk_pin_follow: assert property (
        1'b1 |=> pin_oe_q == ($past(gate_vec) & $past(wave_drive))
            && pin_out_q == ($past(gate_vec) & $past(wave_lvl)))
        else $error("pin output differs from gated waveform");

    chk_open_pin_lag: assert property (
        s_open_ch3_pin_b ##1 (wave_drive[`TSY_GATE_CH3_PIN_B] && wave_lvl[`TSY_GATE_CH3_PIN_B])
        |=> pin_oe_q[`TSY_GATE_CH3_PIN_B] && pin_out_q[`TSY_GATE_CH3_PIN_B])
        else $error("opened gate did not pass the waveform in two cycles");

endmodule : tsy_top

/* File: tsy_top_test.sv */
// self-checking bench for the timer sync and output gate top level
// assumes tsy_map.svh on the include path and the design compiled before this file
`include "tsy_map.svh"

module tsy_top_test;
    timeunit 1ns;
    timeprecision 100ps;

    // ====================================================
    // stimulus and observed signals
    logic                    clk;
    logic                    nrst;
    logic [`TSY_ADDR_W-1:0]  reg_addr;
    tsy_pkg::tsy_reg_t       reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    tsy_pkg::tsy_reg_t       reg_rdata_q;
    tsy_pkg::tsy_chan_t      cnt_wr_req;
    logic [15:0]             cnt_wr_data;
    tsy_pkg::tsy_chan_t      clr_event;
    tsy_pkg::tsy_chan_t      clr_src_sync;
    tsy_pkg::tsy_chan_t      preset_en_q;
    logic [15:0]             preset_val_q;
    tsy_pkg::tsy_chan_t      clear_q;
    tsy_pkg::tsy_pin_t       wave_lvl;
    tsy_pkg::tsy_pin_t       wave_drive;
    tsy_pkg::tsy_pin_t       pin_out_q;
    tsy_pkg::tsy_pin_t       pin_oe_q;
    int                      err_total;
    int                      checked;
    tsy_pkg::tsy_reg_t       rv;

    tsy_top #(.CNT_W(16)) i_tsy_top (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .cnt_wr_req(cnt_wr_req), .cnt_wr_data(cnt_wr_data), .clr_event(clr_event),
        .clr_src_sync(clr_src_sync), .preset_en_q(preset_en_q), .preset_val_q(preset_val_q),
        .clear_q(clear_q), .wave_lvl(wave_lvl), .wave_drive(wave_drive),
        .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q)
    );

    // ====================================================
    // clock, 4 ns period
    always #2 clk = ~clk;

    // ====================================================
    // shared helpers: compare, bus cycles, verdict
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one-cycle write strobe, released at the sampling edge
    task automatic wr(input logic [3:0] a, input tsy_pkg::tsy_reg_t d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe edge, so sample just past it
    task automatic rd(input logic [3:0] a, output tsy_pkg::tsy_reg_t d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask : rd

    // write then read of one register on back-to-back strobes
    task automatic wr_rd(input logic [3:0] a, input tsy_pkg::tsy_reg_t d, output tsy_pkg::tsy_reg_t q);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk);
        reg_rd    <= 1'b0;
        #1;
        q = reg_rdata_q;
    endtask : wr_rd

    // one pulse on the counter side, outputs judged one cycle later
    task automatic pulse(input tsy_pkg::tsy_chan_t wq, input tsy_pkg::tsy_chan_t cl, input logic [15:0] dv);
        @(posedge clk);
        cnt_wr_req  <= wq;
        clr_event   <= cl;
        cnt_wr_data <= dv;
        @(posedge clk);
        cnt_wr_req  <= 5'h00;
        clr_event   <= 5'h00;
        #1;
    endtask : pulse

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // ====================================================
    // scenarios
    task automatic test_reset();
        rd(`TSY_OFS_SYNC_SEL, rv);
        chk("sync reset", 16'h0000, {8'h00, rv});
        rd(`TSY_OFS_OUT_MASTER, rv);
        chk("gate reset", 16'h00C0, {8'h00, rv});
        chk("oe reset", 16'h0000, {10'h000, pin_oe_q});
        $display("test_reset finished");
    endtask : test_reset

    // reserved bits, unmapped address and back-to-back write then read
    task automatic test_regs();
        wr_rd(`TSY_OFS_SYNC_SEL, 8'hFF, rv);
        chk("sync rw", 16'h00C7, {8'h00, rv});
        wr(`TSY_OFS_OUT_MASTER, 8'h00);
        rd(`TSY_OFS_OUT_MASTER, rv);
        chk("gate fixed ones", 16'h00C0, {8'h00, rv});
        wr_rd(`TSY_OFS_OUT_MASTER, 8'hFF, rv);
        chk("gate rw", 16'h00FF, {8'h00, rv});
        wr(4'h2, 8'h5A);
        rd(4'h2, rv);
        chk("unmapped read", 16'h0000, {8'h00, rv});
        @(posedge clk);
        #1;
        chk("rdata idle", 16'h0000, {8'h00, reg_rdata_q});
        $display("test_regs finished");
    endtask : test_regs

    // group of channels 3 and 0 presets together, channel 2 stays alone
    task automatic test_preset();
        wr(`TSY_OFS_SYNC_SEL, 8'h41);
        pulse(5'h01, 5'h00, 16'h1234);
        chk("group preset", 16'h0009, {11'h000, preset_en_q});
        chk("preset value", 16'h1234, preset_val_q);
        pulse(5'h04, 5'h00, 16'hBEEF);
        chk("lone preset", 16'h0004, {11'h000, preset_en_q});
        pulse(5'h08, 5'h00, 16'h0001);
        chk("preset from ch3", 16'h0009, {11'h000, preset_en_q});
        $display("test_preset finished");
    endtask : test_preset

    // clears spread only where both sync bit and clear source agree
    task automatic test_clear();
        @(posedge clk);
        clr_src_sync <= 5'h08;
        pulse(5'h00, 5'h01, 16'h0000);
        chk("group clear", 16'h0009, {11'h000, clear_q});
        pulse(5'h00, 5'h08, 16'h0000);
        chk("no source clear", 16'h0008, {11'h000, clear_q});
        @(posedge clk);
        clr_src_sync <= 5'h1F;
        pulse(5'h00, 5'h04, 16'h0000);
        chk("lone clear", 16'h0004, {11'h000, clear_q});
        $display("test_clear finished");
    endtask : test_clear

    // walk one open gate across the six pins, pins answer one cycle after the write edge
    task automatic test_gate();
        // gate programmed before the pins ask for drive
        wr(`TSY_OFS_OUT_MASTER, 8'hC1);
        @(posedge clk);
        wave_drive <= 6'h3F;
        wave_lvl   <= 6'h3F;
        for (int i = 0; i < 6; i++) begin
            wr(`TSY_OFS_OUT_MASTER, 8'hC0 | (8'h01 << i));
            @(posedge clk);
            #1;
            chk("pin oe", 16'h0001 << i, {10'h000, pin_oe_q});
            chk("pin out", 16'h0001 << i, {10'h000, pin_out_q});
        end
        // level and drive differ here, so a swap between them shows up
        wr(`TSY_OFS_OUT_MASTER, 8'hFF);
        @(posedge clk);
        wave_lvl <= 6'h15;
        @(posedge clk);
        #1;
        chk("pin level", 16'h0015, {10'h000, pin_out_q});
        chk("pin drive", 16'h003F, {10'h000, pin_oe_q});
        wr(`TSY_OFS_OUT_MASTER, 8'hC0);
        @(posedge clk);
        #1;
        chk("all closed", 16'h0000, {10'h000, pin_oe_q | pin_out_q});
        $display("test_gate finished");
    endtask : test_gate

    // reset in mid-run brings both registers and the pins back to idle
    task automatic test_mid_reset();
        wr(`TSY_OFS_SYNC_SEL, 8'hC7);
        wr(`TSY_OFS_OUT_MASTER, 8'hFF);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("oe in reset", 16'h0000, {10'h000, pin_oe_q});
        @(posedge clk);
        nrst <= 1'b1;
        rd(`TSY_OFS_SYNC_SEL, rv);
        chk("sync after reset", 16'h0000, {8'h00, rv});
        rd(`TSY_OFS_OUT_MASTER, rv);
        chk("gate after reset", 16'h00C0, {8'h00, rv});
        $display("test_mid_reset finished");
    endtask : test_mid_reset

    // ====================================================
    // main sequence: reset for 3 cycles, then each scenario in turn
    initial begin
        clk          = 1'b0;
        nrst         = 1'b0;
        reg_addr     = '0;
        reg_wdata    = 8'h00;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        cnt_wr_req   = 5'h00;
        cnt_wr_data  = 16'h0000;
        clr_event    = 5'h00;
        clr_src_sync = 5'h00;
        wave_lvl     = 6'h00;
        wave_drive   = 6'h00;
        err_total    = 0;
        checked      = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        test_reset();
        test_regs();
        test_preset();
        test_clear();
        test_gate();
        test_mid_reset();
        conclude();
    end
endmodule : tsy_top_test
